// ===== core/table_lookup_interpolator.sv
// Execution datapath for the table lookup and interpolate instructions.
// Assumes the sequencer holds operands stable and the memory bus answers reads with ack.
`timescale 1ns/10ps
module table_lookup_interpolator (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic START,
  input wire tbl_pkg::variant_t VARIANT,
  input wire tbl_pkg::size_t SIZE,
  input wire logic REG_PAIR,
  input wire logic [31:0] EA,
  input wire logic [31:0] INDEP_VAR,
  input wire logic [31:0] PAIR_LOW,
  input wire logic [31:0] PAIR_HIGH,
  input wire logic [31:0] SURFACE_DEST,
  output logic MEM_REQ,
  output logic [31:0] MEM_ADDR,
  output tbl_pkg::size_t MEM_SIZE,
  input wire logic MEM_ACK,
  input wire logic [31:0] MEM_RDATA,
  output logic BUSY,
  output logic DONE,
  output logic [31:0] RESULT
);
  typedef enum logic [2:0] {S_IDLE, S_RD0, S_RD1, S_CALC} state_t;
  state_t state_q, state_d;
  tbl_pkg::variant_t var_q, var_d;
  tbl_pkg::size_t size_q, size_d;
  logic [31:0] y0_q, y0_d, y1_q, y1_d, addr_q, addr_d, res_q, res_d;
  logic [7:0] frac_q, frac_d;
  logic req_q, req_d, done_q, done_d, busy_q, busy_d;
  logic signed [32:0] ext0, ext1;
  logic signed [63:0] math_res;

  function automatic logic [31:0] size_bytes(input tbl_pkg::size_t s);
    unique case (s)
      tbl_pkg::SZ_BYTE: size_bytes = 32'(tbl_pkg::SIZE_BYTES_B);
      tbl_pkg::SZ_WORD: size_bytes = 32'(tbl_pkg::SIZE_BYTES_W);
      default: size_bytes = 32'(tbl_pkg::SIZE_BYTES_L);
    endcase
  endfunction : size_bytes

  function automatic logic signed [32:0] extend(input logic [31:0] v, input tbl_pkg::size_t s,
                                                input logic sgn);
    unique case (s)
      tbl_pkg::SZ_BYTE: extend = sgn ? 33'(signed'(v[7:0])) : {25'h0, v[7:0]};
      tbl_pkg::SZ_WORD: extend = sgn ? 33'(signed'(v[15:0])) : {17'h0, v[15:0]};
      default: extend = sgn ? 33'(signed'(v)) : {1'b0, v};
    endcase
  endfunction : extend

  function automatic logic is_signed(input tbl_pkg::variant_t v);
    is_signed = (v == tbl_pkg::TABLE_SIGNED_ROUNDED) || (v == tbl_pkg::TABLE_SIGNED_UNROUNDED);
  endfunction : is_signed

  function automatic logic is_rounded(input tbl_pkg::variant_t v);
    is_rounded = (v == tbl_pkg::TABLE_SIGNED_ROUNDED) || (v == tbl_pkg::TABLE_UNSIGNED_ROUNDED);
  endfunction : is_rounded

  // End values are extended at the operand size, so register pairs may carry
  // word or long-word scaled results of an earlier unrounded pass.
  assign ext0 = extend(y0_q, size_q, is_signed(var_q));
  assign ext1 = extend(y1_q, size_q, is_signed(var_q));

  tbl_interp_math u_math (
    .y0(ext0),
    .y1(ext1),
    .frac(frac_q),
    .round_en(is_rounded(var_q)),
    .result(math_res)
  );

  always_comb begin
    state_d = state_q;
    var_d = var_q;
    size_d = size_q;
    y0_d = y0_q;
    y1_d = y1_q;
    addr_d = addr_q;
    res_d = res_q;
    frac_d = frac_q;
    req_d = req_q;
    done_d = 1'b0;
    unique case (state_q)
      S_IDLE: begin
        if (START) begin
          var_d = VARIANT;
          size_d = SIZE;
          if (REG_PAIR) begin
            y0_d = PAIR_LOW;
            y1_d = PAIR_HIGH;
            frac_d = SURFACE_DEST[7:0];
            state_d = S_CALC;
          end else begin
            frac_d = INDEP_VAR[tbl_pkg::FRAC_LSB +: tbl_pkg::FRAC_W];
            addr_d = EA + 32'(INDEP_VAR[tbl_pkg::OFFS_LSB +: tbl_pkg::OFFS_W]) * size_bytes(SIZE);
            req_d = 1'b1;
            state_d = S_RD0;
          end
        end
      end
      S_RD0: begin
        if (MEM_ACK) begin
          y0_d = MEM_RDATA;
          addr_d = addr_q + size_bytes(size_q);
          state_d = S_RD1;
        end
      end
      S_RD1: begin
        if (MEM_ACK) begin
          y1_d = MEM_RDATA;
          req_d = 1'b0;
          state_d = S_CALC;
        end
      end
      S_CALC: begin
        res_d = math_res[31:0];
        done_d = 1'b1;
        state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
    // BUSY is registered from the next state so that it rises on the edge that takes START.
    busy_d = (state_d != S_IDLE);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= S_IDLE;
      var_q <= tbl_pkg::TABLE_SIGNED_ROUNDED;
      size_q <= tbl_pkg::SZ_BYTE;
      y0_q <= tbl_pkg::RESULT_RST;
      y1_q <= tbl_pkg::RESULT_RST;
      addr_q <= tbl_pkg::RESULT_RST;
      res_q <= tbl_pkg::RESULT_RST;
      frac_q <= 8'h00;
      req_q <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (CE) begin
      state_q <= state_d;
      var_q <= var_d;
      size_q <= size_d;
      y0_q <= y0_d;
      y1_q <= y1_d;
      addr_q <= addr_d;
      res_q <= res_d;
      frac_q <= frac_d;
      req_q <= req_d;
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  assign MEM_REQ = req_q;
  assign MEM_ADDR = addr_q;
  assign MEM_SIZE = size_q;
  assign BUSY = busy_q;
  assign DONE = done_q;
  assign RESULT = res_q;

  // Variant coverage: each of the four results flows through the same path.

  sequence second_ack_s;
    CE && state_q == S_RD1 && MEM_ACK;
  endsequence

  sequence calc_then_done_s;
    (state_q == S_CALC && !MEM_REQ) ##1 (DONE || !$past(CE));
  endsequence

  first_addr_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && state_q == S_IDLE && START && !REG_PAIR) |=> (MEM_REQ && MEM_ADDR ==
      $past(EA) + 32'($past(INDEP_VAR[15:8])) * size_bytes(size_q)))
    else $error("first entry address wrong");
  addr_wait_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && state_q == S_RD0 && !MEM_ACK) |=> (state_q == S_RD0 && $stable(MEM_ADDR)))
    else $error("first fetch left before its answer");

  pair_fast_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && state_q == S_IDLE && START && REG_PAIR) |=> (state_q == S_CALC))
    else $error("register pair did not skip fetch");
  frac_take_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && state_q == S_IDLE && START && !REG_PAIR) |=> (frac_q == $past(INDEP_VAR[7:0])))
    else $error("fraction not from low byte");
  surf_frac_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && state_q == S_IDLE && START && REG_PAIR) |=> (frac_q == $past(SURFACE_DEST[7:0])))
    else $error("surface fraction wrong");
  second_addr_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && state_q == S_RD0 && MEM_ACK) |=> (MEM_ADDR == $past(MEM_ADDR) + size_bytes(size_q)))
    else $error("second entry not adjacent");
  req_hold_a: assert property (@(posedge CLK) disable iff (RST)
    (state_q == S_RD0 || state_q == S_RD1) |-> MEM_REQ)
    else $error("request dropped during fetch");
  done_after_a: assert property (@(posedge CLK) disable iff (RST)
    (CE && state_q == S_CALC) |=> (DONE && RESULT == $past(math_res[31:0])))
    else $error("result not registered");
  unround_scale_a: assert property (@(posedge CLK) disable iff (RST)
    (state_q == S_CALC && !is_rounded(var_q) && frac_q == 8'h00)
      |-> (math_res[7:0] == 8'h00))
    else $error("unrounded zero fraction not scaled");
  round_equal_a: assert property (@(posedge CLK) disable iff (RST)
    (state_q == S_CALC && is_rounded(var_q) && y0_q == y1_q) |-> (math_res == 64'(ext0)))
    else $error("rounding moved an exact value");
  unsigned_ext_a: assert property (@(posedge CLK) disable iff (RST)
    (state_q == S_CALC && !is_signed(var_q)) |-> !ext0[32])
    else $error("unsigned end value sign extended");
  fetch_done_a: assert property (@(posedge CLK) disable iff (RST)
    second_ack_s |=> calc_then_done_s)
    else $error("fetch did not complete");
endmodule : table_lookup_interpolator

// ===== core/tbl_interp_math.sv
// Combinational interpolation arithmetic for one pair of end values.
// Assumes end values already sign or zero extended to 33 bits by the caller.
`timescale 1ns/10ps
module tbl_interp_math (
  input wire logic signed [32:0] y0,
  input wire logic signed [32:0] y1,
  input wire logic [7:0] frac,
  input wire logic round_en,
  output logic signed [63:0] result
);
  logic signed [63:0] diff;
  logic signed [63:0] scaled;
  logic signed [63:0] rounded;
  logic [7:0] rem;
  always_comb begin
    diff = 64'(y1) - 64'(y0);
    // Value scaled by 256: the fraction stays in the low byte.
    scaled = (64'(y0) <<< tbl_pkg::FRAC_BITS) + diff * $signed({56'h0, frac});
    rem = scaled[7:0];
    rounded = scaled >>> tbl_pkg::FRAC_BITS;
    // Round to nearest, halfway goes to the even integer.
    if (rem > 8'h80 || (rem == 8'h80 && rounded[0])) begin
      rounded = rounded + 64'sh1;
    end
    result = round_en ? rounded : scaled;
  end
endmodule : tbl_interp_math

// ===== include/tbl_pkg.sv
// Constants for the table lookup and interpolate datapath.
// Assumes a single core clock domain; no software-visible registers.
package tbl_pkg;
  localparam int DATA_W = 32;
  localparam int FRAC_LSB = 0;
  localparam int FRAC_W = 8;
  localparam int OFFS_LSB = 8;
  localparam int OFFS_W = 8;
  localparam int FRAC_BITS = 8;
  localparam int LEVELS = 256;
  localparam int SIZE_BYTES_B = 1;
  localparam int SIZE_BYTES_W = 2;
  localparam int SIZE_BYTES_L = 4;
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} size_t;
  typedef enum logic [1:0] {
    TABLE_SIGNED_ROUNDED,
    TABLE_SIGNED_UNROUNDED,
    TABLE_UNSIGNED_ROUNDED,
    TABLE_UNSIGNED_UNROUNDED
  } variant_t;
endpackage : tbl_pkg

// ===== verification/operand_mem_model.sv
// Operand memory model answering table reads after random wait states.
// Assumes the datapath holds each read request until it is acknowledged.
`timescale 1ns/10ps
module operand_mem_model (
  input wire logic clk,
  input wire logic req,
  input wire logic [31:0] addr,
  output logic ack,
  output logic [31:0] rdata
);
  int seed = 7;
  int wait_q = 0;
  int n_rd = 0;
  logic [31:0] addr_log [2];
  function automatic logic [31:0] entry(input logic [31:0] a);
    return (a * 32'h9e3779b1) ^ 32'h00005a5a;
  endfunction : entry
  initial ack = 1'b0;
  initial rdata = 32'h0;
  // Idle data flips every cycle so a stale word never passes.
  always @(posedge clk) begin
    rdata <= ~rdata;
    ack <= 1'b0;
    if (req && !ack) begin
      if (wait_q == 0) begin
        ack <= 1'b1;
        rdata <= entry(addr);
        addr_log[n_rd % 2] <= addr;
        n_rd <= n_rd + 1;
        wait_q <= $unsigned($random(seed)) % 3;
      end else begin
        wait_q <= wait_q - 1;
      end
    end
  end
endmodule : operand_mem_model

// ===== verification/test_table_lookup_interpolator.sv
// Self-checking bench for the table lookup and interpolate datapath.
// Assumes the operand memory model answers the datapath's reads.
`timescale 1ns/10ps
module test_table_lookup_interpolator;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic rp_r = 1'b0;
  tbl_pkg::variant_t var_r = tbl_pkg::TABLE_SIGNED_ROUNDED;
  tbl_pkg::size_t sz_r = tbl_pkg::SZ_BYTE;
  logic [31:0] ea_r = 32'h0, iv_r = 32'h0, lo_r = 32'h0, hi_r = 32'h0, sd_r = 32'h0;
  logic mem_req, mem_ack, busy, done;
  logic ce_r = 1'b1;
  tbl_pkg::size_t mem_size;
  logic [31:0] mem_addr, mem_rdata, result;
  int seed = 65139;
  int n_errors = 0;
  int n_checks = 0;
  always #12.5 clk = ~clk;
  table_lookup_interpolator i_table_lookup_interpolator (.CLK(clk), .RST(rst), .CE(ce_r),
    .START(start), .VARIANT(var_r), .SIZE(sz_r), .REG_PAIR(rp_r), .EA(ea_r),
    .INDEP_VAR(iv_r), .PAIR_LOW(lo_r), .PAIR_HIGH(hi_r), .SURFACE_DEST(sd_r),
    .MEM_REQ(mem_req), .MEM_ADDR(mem_addr), .MEM_SIZE(mem_size), .MEM_ACK(mem_ack),
    .MEM_RDATA(mem_rdata), .BUSY(busy), .DONE(done), .RESULT(result));
  operand_mem_model i_operand_mem_model (.clk(clk), .req(mem_req), .addr(mem_addr),
    .ack(mem_ack), .rdata(mem_rdata));
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] want(input int v, input int sz, input logic [31:0] a,
      input logic [31:0] b, input logic [7:0] f);
    longint y0, y1, full, q;
    int w;
    w = 8 << sz;
    y0 = a & ((64'h1 << w) - 1);
    y1 = b & ((64'h1 << w) - 1);
    if (v < 2 && a[w-1]) y0 = y0 - (64'sh1 << w);
    if (v < 2 && b[w-1]) y1 = y1 - (64'sh1 << w);
    full = y0 * 256 + longint'(f) * (y1 - y0);
    if (v % 2 == 1) return full[31:0];
    q = full >>> 8;
    if ((full & 255) > 128 || ((full & 255) == 128 && q[0])) q++;
    return q[31:0];
  endfunction : want
  task automatic run(input int v, input int sz, input logic rp, input logic [31:0] ea,
      input logic [31:0] iv, input logic [31:0] lo, input logic [31:0] hi,
      input logic [31:0] sd);
    logic [31:0] e, nb, a0;
    int t;
    nb = 32'h1 << sz;
    a0 = ea + iv[15:8] * nb;
    e = rp ? want(v, sz, lo, hi, sd[7:0]) : want(v, sz, i_operand_mem_model.entry(a0),
      i_operand_mem_model.entry(a0 + nb), iv[7:0]);
    @(posedge clk);
    var_r <= tbl_pkg::variant_t'(v);
    sz_r <= tbl_pkg::size_t'(sz);
    rp_r <= rp;
    ea_r <= ea;
    iv_r <= iv;
    lo_r <= lo;
    hi_r <= hi;
    sd_r <= sd;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    chk({31'h0, busy}, 32'h1);
    t = 0;
    do begin
      @(posedge clk);
      #1;
      t++;
    end while (done !== 1'b1 && t < 100);
    chk({30'h0, busy, done}, 32'h1);
    chk(result, e);
    if (!rp) begin
      chk({30'h0, mem_size}, 32'(sz));
      chk(i_operand_mem_model.addr_log[0], a0);
      chk(i_operand_mem_model.addr_log[1], a0 + nb);
    end
    $display("test done variant %0d size %0d pair %0d", v, sz, rp);
  endtask : run
  // Register-pair pass with the clock enable low for a while after the take.
  task automatic freeze(input logic [31:0] lo, input logic [31:0] hi, input logic [7:0] f);
    logic [31:0] e;
    e = want(1, 1, lo, hi, f);
    @(posedge clk);
    var_r <= tbl_pkg::TABLE_SIGNED_UNROUNDED;
    sz_r <= tbl_pkg::SZ_WORD;
    rp_r <= 1'b1;
    lo_r <= lo;
    hi_r <= hi;
    sd_r <= {24'h0, f};
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    ce_r <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk({30'h0, busy, done}, 32'h2);
    @(posedge clk);
    ce_r <= 1'b1;
    @(posedge clk);
    #1;
    chk({30'h0, busy, done}, 32'h1);
    chk(result, e);
    $display("test done freeze pair");
  endtask : freeze
  initial begin
    repeat (16) @(posedge clk);
    chk({29'h0, busy, done, mem_req}, 32'h0);
    chk(result, 32'h0);
    rst <= 1'b0;
    run(0, 0, 1'b1, 0, 0, 32'h0, 32'h1, 32'h80);
    run(0, 0, 1'b1, 0, 0, 32'h1, 32'h2, 32'h80);
    run(0, 1, 1'b1, 0, 0, 32'h2070, 32'h3f70, 32'hff);
    run(2, 2, 1'b1, 0, 0, 32'hffff_ff00, 32'h0, 32'h01);
    run(0, 0, 1'b1, 0, 0, 32'h7f, 32'h7f, 32'h5a);
    freeze(32'h0123, 32'h8001, 8'h00);
    for (int k = 0; k < 48; k++) begin
      run(k % 4, (k / 4) % 3, k[4] ^ k[3], $random(seed), $random(seed), $random(seed),
        $random(seed), $random(seed));
    end
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_sim;
  end
endmodule : test_table_lookup_interpolator
